/* File: vam_pkg.sv */
// package: register map, field layout, reset values and timing of the voltage angle memory
package vam_pkg;

    // register byte offsets
    localparam logic [7:0] VAM_OFS_CTRL = 8'h00;
    localparam logic [7:0] VAM_OFS_ARM = 8'h04;
    localparam logic [7:0] VAM_OFS_CURQ = 8'h08;
    localparam logic [7:0] VAM_OFS_TLIM = 8'h0C;
    localparam logic [7:0] VAM_OFS_VUSE = 8'h10;
    localparam logic [7:0] VAM_OFS_STATUS = 8'h14;
    localparam logic [7:0] VAM_OFS_EVT = 8'h18;
    localparam logic [7:0] VAM_OFS_MASK = 8'h1C;
    localparam logic [7:0] VAM_OFS_HOLD = 8'h20;
    localparam logic [7:0] VAM_OFS_SAMPF = 8'h24;

    // control register layout, bit 7 downward
    typedef struct packed {
        logic sync4_used;
        logic sync3_used;
        logic sync_mode;
        logic freq_track;
        logic nom60;
        logic cur_follow;
        logic cur_qual_en;
        logic enable;
    } vam_ctrl_s;

    localparam int VAM_CTRL_W = 8;
    localparam logic [7:0] VAM_CTRL_RST = 8'h00;

    // voltage in 0.01 V steps, time limit in 10 ms steps
    localparam logic [15:0] VAM_ARM_MIN = 16'h00C8;
    localparam logic [15:0] VAM_ARM_MAX = 16'h1388;
    localparam logic [15:0] VAM_ARM_RST = 16'h00C8;
    localparam logic [15:0] VAM_CURQ_RST = 16'h0000;
    localparam logic [12:0] VAM_TLIM_MIN = 13'h0002;
    localparam logic [12:0] VAM_TLIM_MAX = 13'h1388;
    localparam logic [12:0] VAM_TLIM_RST = 13'h0032;
    localparam logic [5:0] VAM_VUSE_RST = 6'h3F;

    // angles in 0.01 degree, frequencies in 0.01 Hz
    localparam logic [15:0] VAM_ANG_FULL = 16'h8CA0;
    localparam logic [15:0] VAM_NOM_50 = 16'h1388;
    localparam logic [15:0] VAM_NOM_60 = 16'h1770;

    // event bits
    localparam int VAM_EV_N = 12;
    localparam int VAM_EV_EN = 0;
    localparam int VAM_EV_DIS = 1;
    localparam int VAM_EV_LOW_ON = 2;
    localparam int VAM_EV_LOW_OFF = 3;
    localparam int VAM_EV_HIGH_ON = 4;
    localparam int VAM_EV_HIGH_OFF = 5;
    localparam int VAM_EV_FCUR_ON = 6;
    localparam int VAM_EV_FCUR_OFF = 7;
    localparam int VAM_EV_USE_ON = 8;
    localparam int VAM_EV_USE_OFF = 9;
    localparam int VAM_EV_BLK_ON = 10;
    localparam int VAM_EV_BLK_OFF = 11;

    // time base of the engaged-time limit
    localparam longint VAM_CLK_PERIOD_PS = 40000;
    localparam longint VAM_TIME_STEP_MS = 10;
    localparam int VAM_TICK_CYCLES = int'((VAM_TIME_STEP_MS * 1000000000) / VAM_CLK_PERIOD_PS);

    typedef enum logic [1:0] {
        VAM_IDLE,
        VAM_ENGAGED,
        VAM_EXPIRED
    } vam_phase_e;

endpackage

/* File: vam_core.sv */
// voltage angle memory: engagement, held reference, time limit, events and apb registers
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps

module vam_core
    import vam_pkg::*;
#(
    parameter int NV = 6,
    parameter int TICK_CYCLES = VAM_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cycle_strobe,
    input wire logic [NV*16-1:0] volt_mag,
    input wire logic [NV*16-1:0] volt_ang,
    input wire logic [47:0] cur_mag,
    input wire logic [15:0] volt_freq,
    input wire logic [15:0] cur3_freq,
    input wire logic [31:0] sync_ang_in,
    input wire logic block_in,
    output logic mem_in_use,
    output logic fallback_nondir,
    output logic [15:0] ref_amplitude,
    output logic [NV*16-1:0] ref_angle,
    output logic sync_ang_valid,
    output logic [31:0] sync_ang,
    output logic [15:0] samp_freq,
    output logic freq_from_current,
    output logic [VAM_EV_N-1:0] event_pulse,
    output logic irq
);

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    typedef struct packed {
        vam_phase_e phase;
        logic in_use;
        vam_ctrl_s ctrl;
        logic [15:0] arm;
        logic [15:0] curq;
        logic [12:0] tlim;
        logic [NV-1:0] vuse;
        logic [VAM_EV_N-1:0] evt;
        logic [VAM_EV_N-1:0] msk;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [TW-1:0] tick;
        logic [12:0] tmr;
        logic blk;
        logic low;
        logic high;
        logic fcur;
        logic en_prev;
        logic [NV*16-1:0] prev_ang;
        logic [NV*16-1:0] ref_ang;
        logic [15:0] ref_amp;
        logic fallback;
        logic sync_valid;
        logic [31:0] sync_ang;
        logic [15:0] samp_freq;
        logic [VAM_EV_N-1:0] ev_pulse;
        logic irq;
    } vam_state_s;

    vam_state_s s_r;
    vam_state_s s_nxt;
    logic rst_sync1_r;
    logic rst_sync2_r;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // wrap a raw angle into 0..359.99 degrees
    function automatic logic [15:0] wrap_ang(input logic [15:0] a);
        wrap_ang = (a >= VAM_ANG_FULL) ? 16'(a - VAM_ANG_FULL) : a;
    endfunction

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            VAM_OFS_CTRL, VAM_OFS_ARM, VAM_OFS_CURQ, VAM_OFS_TLIM, VAM_OFS_VUSE,
            VAM_OFS_STATUS, VAM_OFS_EVT, VAM_OFS_MASK, VAM_OFS_HOLD, VAM_OFS_SAMPF: begin
                is_mapped = 1'b1;
            end
            default: begin
                is_mapped = 1'b0;
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // measurement conditions

    logic [NV-1:0] v_below;
    logic [2:0] i_above;
    logic [NV*16-1:0] ang_wrapped;
    logic low_now;
    logic high_now;

    genvar g;
    generate
        for (g = 0; g < NV; g = g + 1) begin : g_volt
            // unused channels count as below so they never hold off engagement
            assign v_below[g] = !s_r.vuse[g] || (volt_mag[g*16 +: 16] < s_r.arm);
            assign ang_wrapped[g*16 +: 16] = wrap_ang(volt_ang[g*16 +: 16]);
        end
        for (g = 0; g < 3; g = g + 1) begin : g_cur
            assign i_above[g] = cur_mag[g*16 +: 16] > s_r.curq;
        end
    endgenerate

    // with no channel in use the condition can never be met
    assign low_now = (&v_below) && (|s_r.vuse);
    assign high_now = |i_above;

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    logic setup;
    logic access;
    logic wr;
    logic [VAM_EV_N-1:0] ev_set;
    logic [VAM_EV_N-1:0] ev_clr;
    logic tick_done;
    logic expired;
    logic qual_ok;
    logic engage;
    logic drop;
    logic [15:0] wr_lo;
    logic [31:0] rd;

    always_comb begin
        s_nxt = s_r;
        setup = psel && !penable;
        access = psel && penable && s_r.pready;
        wr = access && pwrite && is_mapped(paddr);
        wr_lo = pwdata[15:0];
        ev_set = '0;
        ev_clr = '0;
        rd = 32'h0000_0000;

        // register writes
        if (wr) begin
            case (paddr)
                VAM_OFS_CTRL: begin
                    s_nxt.ctrl = vam_ctrl_s'(pwdata[VAM_CTRL_W-1:0]);
                end
                VAM_OFS_ARM: begin
                    s_nxt.arm = clamp16(wr_lo, VAM_ARM_MIN, VAM_ARM_MAX);
                end
                VAM_OFS_CURQ: begin
                    s_nxt.curq = wr_lo;
                end
                VAM_OFS_TLIM: begin
                    s_nxt.tlim = 13'(clamp16(wr_lo, 16'(VAM_TLIM_MIN), 16'(VAM_TLIM_MAX)));
                end
                VAM_OFS_VUSE: begin
                    s_nxt.vuse = pwdata[NV-1:0];
                end
                VAM_OFS_EVT: begin
                    ev_clr = pwdata[VAM_EV_N-1:0];
                end
                VAM_OFS_MASK: begin
                    s_nxt.msk = pwdata[VAM_EV_N-1:0];
                end
                default: begin
                end
            endcase
        end

        // enable and disable events follow the stored setting
        s_nxt.en_prev = s_r.ctrl.enable;
        if (s_r.ctrl.enable && !s_r.en_prev) begin
            ev_set[VAM_EV_EN] = 1'b1;
        end
        if (!s_r.ctrl.enable && s_r.en_prev) begin
            ev_set[VAM_EV_DIS] = 1'b1;
        end

        // conditions are re-evaluated once per program cycle
        if (cycle_strobe) begin
            s_nxt.blk = block_in;
            s_nxt.low = low_now;
            s_nxt.high = high_now;
            ev_set[VAM_EV_BLK_ON] = block_in && !s_r.blk;
            ev_set[VAM_EV_BLK_OFF] = !block_in && s_r.blk;
            ev_set[VAM_EV_LOW_ON] = low_now && !s_r.low;
            ev_set[VAM_EV_LOW_OFF] = !low_now && s_r.low;
            ev_set[VAM_EV_HIGH_ON] = high_now && !s_r.high;
            ev_set[VAM_EV_HIGH_OFF] = !high_now && s_r.high;
        end

        // engagement timer in 10 ms steps
        tick_done = (s_r.tick == TICK_LAST);
        expired = tick_done && ({1'b0, s_r.tmr} + 14'h0001 >= {1'b0, s_r.tlim});
        qual_ok = !s_r.ctrl.cur_qual_en || high_now;
        engage = cycle_strobe && s_r.ctrl.enable && !block_in && low_now && qual_ok;
        drop = !s_r.ctrl.enable || (cycle_strobe && block_in) || s_r.blk || expired;

        case (s_r.phase)
            VAM_IDLE: begin
                s_nxt.tick = '0;
                s_nxt.tmr = '0;
                s_nxt.fallback = 1'b0;
                if (engage) begin
                    s_nxt.phase = VAM_ENGAGED;
                    // angles from the program cycle just before the engaging one
                    s_nxt.ref_ang = s_r.prev_ang;
                    s_nxt.ref_amp = s_r.arm;
                    ev_set[VAM_EV_USE_ON] = 1'b1;
                end
            end
            VAM_ENGAGED: begin
                if (tick_done) begin
                    s_nxt.tick = '0;
                    s_nxt.tmr = 13'(s_r.tmr + 13'h0001);
                end else begin
                    s_nxt.tick = TW'(s_r.tick + 1'b1);
                end
                if (drop) begin
                    ev_set[VAM_EV_USE_OFF] = 1'b1;
                    s_nxt.tick = '0;
                    // every drop waits for recovery, so one fault gives one period
                    s_nxt.phase = VAM_EXPIRED;
                    s_nxt.fallback = expired;
                end
            end
            VAM_EXPIRED: begin
                s_nxt.tmr = '0;
                if (!s_r.low && !low_now) begin
                    s_nxt.phase = VAM_IDLE;
                    s_nxt.fallback = 1'b0;
                end
            end
            default: begin
                s_nxt.phase = VAM_IDLE;
            end
        endcase

        // reference angle pipeline: keep the angles of each program cycle spent outside engagement
        if (cycle_strobe && s_r.phase != VAM_ENGAGED) begin
            s_nxt.prev_ang = ang_wrapped;
        end
        if (s_nxt.phase != VAM_ENGAGED) begin
            // live reference while not engaged
            s_nxt.ref_ang = s_r.prev_ang;
            s_nxt.ref_amp = 16'h0000;
        end
        s_nxt.in_use = (s_nxt.phase == VAM_ENGAGED);

        // sampling frequency for protection stages other than frequency protection
        s_nxt.fcur = s_r.ctrl.cur_follow && low_now;
        if (s_nxt.fcur) begin
            s_nxt.samp_freq = cur3_freq;
        end else if (!s_r.ctrl.freq_track) begin
            s_nxt.samp_freq = s_r.ctrl.nom60 ? VAM_NOM_60 : VAM_NOM_50;
        end else begin
            s_nxt.samp_freq = volt_freq;
        end
        ev_set[VAM_EV_FCUR_ON] = s_nxt.fcur && !s_r.fcur;
        ev_set[VAM_EV_FCUR_OFF] = !s_nxt.fcur && s_r.fcur;

        // synchrocheck angles
        s_nxt.sync_valid = s_r.ctrl.sync_mode && s_r.ctrl.sync3_used
                           && s_r.ctrl.sync4_used;
        s_nxt.sync_ang = s_nxt.sync_valid
                         ? {wrap_ang(sync_ang_in[31:16]), wrap_ang(sync_ang_in[15:0])}
                         : 32'h0000_0000;

        // sticky events: a set in the clearing cycle wins
        s_nxt.evt = (s_r.evt & ~ev_clr) | ev_set;
        s_nxt.ev_pulse = ev_set;
        s_nxt.irq = |(s_nxt.evt & s_nxt.msk);

        // apb: answer registered during setup, so access completes in one cycle
        case (paddr)
            VAM_OFS_CTRL: begin
                rd = {24'h000000, s_r.ctrl};
            end
            VAM_OFS_ARM: begin
                rd = {16'h0000, s_r.arm};
            end
            VAM_OFS_CURQ: begin
                rd = {16'h0000, s_r.curq};
            end
            VAM_OFS_TLIM: begin
                rd = {19'h00000, s_r.tlim};
            end
            VAM_OFS_VUSE: begin
                rd = 32'(s_r.vuse);
            end
            VAM_OFS_STATUS: begin
                rd = {20'h00000, s_r.tmr == 13'h0000 ? 1'b0 : 1'b1, s_r.phase,
                      s_r.sync_valid, s_r.fallback, s_r.fcur, s_r.blk, s_r.high,
                      s_r.low, s_r.phase == VAM_ENGAGED, s_r.ctrl.enable, 1'b0};
            end
            VAM_OFS_EVT: begin
                rd = 32'(s_r.evt);
            end
            VAM_OFS_MASK: begin
                rd = 32'(s_r.msk);
            end
            VAM_OFS_HOLD: begin
                rd = {16'h0000, s_r.ref_ang[15:0]};
            end
            VAM_OFS_SAMPF: begin
                rd = {16'h0000, s_r.samp_freq};
            end
            default: begin
                rd = 32'h0000_0000;
            end
        endcase
        if (setup) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
            s_nxt.pslverr = !is_mapped(paddr);
        end else begin
            s_nxt.pready = 1'b0;
            s_nxt.pslverr = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reset release and state register

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end else begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end

    always_ff @(posedge clk or negedge rst_sync2_r) begin
        if (!rst_sync2_r) begin
            s_r <= '0;
            s_r.phase <= VAM_IDLE;
            s_r.ctrl <= vam_ctrl_s'(VAM_CTRL_RST);
            s_r.arm <= VAM_ARM_RST;
            s_r.curq <= VAM_CURQ_RST;
            s_r.tlim <= VAM_TLIM_RST;
            s_r.vuse <= VAM_VUSE_RST;
            s_r.samp_freq <= VAM_NOM_50;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign mem_in_use = s_r.in_use;
    assign fallback_nondir = s_r.fallback;
    assign ref_amplitude = s_r.ref_amp;
    assign ref_angle = s_r.ref_ang;
    assign sync_ang_valid = s_r.sync_valid;
    assign sync_ang = s_r.sync_ang;
    assign samp_freq = s_r.samp_freq;
    assign freq_from_current = s_r.fcur;
    assign event_pulse = s_r.ev_pulse;
    assign irq = s_r.irq;

endmodule // vam_core

/* File: vam_core_properties.sv */
// checker: port-level properties of the voltage angle memory
`timescale 1ns/1ps
module vam_core_chk
    import vam_pkg::*;
#(
    parameter int NV = 6,
    parameter int TICK_CYCLES = VAM_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cycle_strobe,
    input wire logic block_in,
    input wire logic mem_in_use,
    input wire logic fallback_nondir,
    input wire logic [15:0] ref_amplitude,
    input wire logic [NV*16-1:0] ref_angle,
    input wire logic [VAM_EV_N-1:0] event_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_strobe_blocked;
        cycle_strobe && block_in && ce;
    endsequence
    // engaged length counted, too long for a repetition
    longint run_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_r <= 0;
        end else if (ce) begin
            run_r <= mem_in_use ? run_r + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_apb_answer: assert property (s_setup |=> pready)
        else $error("no answer one cycle after setup");
    a_pready_pulse: assert property (pready && ce |=> !pready)
        else $error("pready stood longer than one cycle");
    a_unmapped_err: assert property (pready |->
        pslverr == (paddr > VAM_OFS_SAMPF || paddr[1:0] != 2'h0))
        else $error("error response does not match address");
    a_block_drops: assert property (s_strobe_blocked |=> !mem_in_use)
        else $error("memory engaged while blocked");
    a_engage_cause: assert property ($rose(mem_in_use) |->
        $past(cycle_strobe) && !$past(block_in))
        else $error("engagement without unblocked strobe");
    a_amp_arm: assert property (mem_in_use |->
        ref_amplitude inside {[VAM_ARM_MIN:VAM_ARM_MAX]})
        else $error("engaged amplitude outside arm range");
    a_amp_idle: assert property (!mem_in_use |-> ref_amplitude == 16'h0000)
        else $error("amplitude present while not engaged");
    a_angle_held: assert property (mem_in_use && $past(mem_in_use) |-> $stable(ref_angle))
        else $error("reference angle moved while engaged");
    a_use_on_evt: assert property ($rose(mem_in_use) |-> event_pulse[VAM_EV_USE_ON])
        else $error("missing in-use on event");
    a_use_off_evt: assert property ($fell(mem_in_use) |-> event_pulse[VAM_EV_USE_OFF])
        else $error("missing in-use off event");
    a_expiry_fallback: assert property ($rose(fallback_nondir) |-> $fell(mem_in_use))
        else $error("fallback without end of engagement");
    a_engaged_bound: assert property (run_r <= longint'(TICK_CYCLES) * 5000)
        else $error("engaged longer than largest limit");
endmodule // vam_core_chk

bind vam_core vam_core_chk #(.NV(NV), .TICK_CYCLES(TICK_CYCLES)) u_vam_chk (
    .clk(clk), .rst_n(rst_n), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .cycle_strobe(cycle_strobe), .block_in(block_in),
    .mem_in_use(mem_in_use), .fallback_nondir(fallback_nondir),
    .ref_amplitude(ref_amplitude), .ref_angle(ref_angle), .event_pulse(event_pulse)
);

/* File: vam_stage_model.sv */
// partner: directional and distance stages consuming the memory reference
`timescale 1ns/1ps
module vam_stage_model (
    input wire logic clk,
    input wire logic mem_in_use,
    input wire logic fallback_nondir,
    output int engaged_cycles,
    output logic nondir_mode
);
    logic prev_r = 1'b0;
    initial engaged_cycles = 0;
    // length of the last engaged period, as the stages see it
    always @(posedge clk) begin
        prev_r <= mem_in_use;
        if (mem_in_use && !prev_r) engaged_cycles <= 1;
        else if (mem_in_use) engaged_cycles <= engaged_cycles + 1;
        nondir_mode <= fallback_nondir;
    end
endmodule // vam_stage_model

/* File: test_voltage_angle_memory.sv */
// testbench: register access and engagement sequences of the voltage angle memory
`timescale 1ns/1ps
module test_voltage_angle_memory
    import vam_pkg::*;
;
    localparam int TICK = 4;
    logic clk = 0, rst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic cycle_strobe = 0, block_in = 0, err, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, sync_ang;
    logic [95:0] volt_mag = '0, volt_ang = '0, ref_angle;
    logic [47:0] cur_mag = '0;
    logic [15:0] ref_amplitude, samp_freq;
    logic [VAM_EV_N-1:0] event_pulse;
    logic mem_in_use, fallback_nondir, sync_ang_valid, freq_from_current, irq, nondir;
    logic [95:0] ang_a = {16'h0005, 16'h0004, 16'h0003, 16'h0002, 16'h0001, 16'h8CA1};
    logic [7:0] rst_addr [4] = '{VAM_OFS_CTRL, VAM_OFS_ARM, VAM_OFS_TLIM, VAM_OFS_VUSE};
    logic [31:0] rst_val [4] = '{32'h0, 32'h00C8, 32'h0032, 32'h003F};
    int fail_count = 0, n_compared = 0, eng_n;
    always #20 clk = ~clk;
    vam_core #(.NV(6), .TICK_CYCLES(TICK)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cycle_strobe(cycle_strobe),
        .volt_mag(volt_mag), .volt_ang(volt_ang), .cur_mag(cur_mag), .volt_freq(16'h1378),
        .cur3_freq(16'h11F8), .sync_ang_in(32'h1234ABCD), .block_in(block_in),
        .mem_in_use(mem_in_use), .fallback_nondir(fallback_nondir),
        .ref_amplitude(ref_amplitude), .ref_angle(ref_angle), .sync_ang_valid(sync_ang_valid),
        .sync_ang(sync_ang), .samp_freq(samp_freq), .freq_from_current(freq_from_current),
        .event_pulse(event_pulse), .irq(irq));
    vam_stage_model i_stage (.clk(clk), .mem_in_use(mem_in_use),
        .fallback_nondir(fallback_nondir), .engaged_cycles(eng_n), .nondir_mode(nondir));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // request held until pready is sampled high at a rising edge
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        // settings written reach the registered outputs one cycle later
        repeat (2) @(negedge clk);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    // magnitudes and angles change with the strobe so both are seen at one cycle start
    task automatic strobe(input logic [15:0] m, input logic [95:0] ang);
        @(posedge clk);
        volt_mag <= {6{m}};
        volt_ang <= ang;
        cycle_strobe <= 1;
        @(posedge clk);
        cycle_strobe <= 0;
        @(negedge clk);
    endtask
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(40 * 6000);
        fail_count++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 4; i++) rchk("reset value", rst_addr[i], rst_val[i]);
        apb(1, 8'h40, 32'h1);
        chk("unmapped error", 32'(err), 32'h1);
        apb(1, VAM_OFS_ARM, 32'h1);
        rchk("arm low clamp", VAM_OFS_ARM, 32'h00C8);
        apb(1, VAM_OFS_ARM, 32'hFFFF);
        rchk("arm high clamp", VAM_OFS_ARM, 32'h1388);
        apb(1, VAM_OFS_TLIM, 32'h1);
        rchk("limit low clamp", VAM_OFS_TLIM, 32'h0002);
        apb(1, VAM_OFS_ARM, 32'h03E8);
        apb(1, VAM_OFS_MASK, 32'hFFF);
        strobe(16'h0064, ang_a);
        chk("disabled engage", 32'(mem_in_use), 32'h0);
        strobe(16'h4E20, ang_a);
        apb(1, VAM_OFS_CTRL, 32'h01);
        strobe(16'h4E20, ang_a);
        strobe(16'h0064, {6{16'h1000}});
        chk("engaged", 32'(mem_in_use), 32'h1);
        chk("amplitude", 32'(ref_amplitude), 32'h03E8);
        chk("held angle", ref_angle[31:0], 32'h00010001);
        chk("held angle top", 32'(ref_angle[95:80]), 32'h0005);
        for (int n = 0; n < 100 && mem_in_use === 1'b1; n++) @(negedge clk);
        chk("engaged length", 32'(eng_n), 32'(2 * TICK));
        chk("fallback", 32'(fallback_nondir), 32'h1);
        @(negedge clk);
        chk("stage mode", 32'(nondir), 32'h1);
        chk("irq raised", 32'(irq), 32'h1);
        apb(0, VAM_OFS_EVT, 32'h0);
        chk("events", rd & 32'h305, 32'h305);
        apb(1, VAM_OFS_EVT, 32'hFFF);
        chk("irq cleared", 32'(irq), 32'h0);
        strobe(16'h0064, {6{16'h1000}});
        chk("no re-engage", 32'(mem_in_use), 32'h0);
        strobe(16'h4E20, {6{16'h1000}});
        @(negedge clk);
        chk("fallback ends", 32'(fallback_nondir), 32'h0);
        strobe(16'h0064, {6{16'h1000}});
        chk("re-armed", 32'(mem_in_use), 32'h1);
        @(posedge clk) block_in <= 1;
        strobe(16'h0064, {6{16'h1000}});
        chk("block drops", 32'(mem_in_use), 32'h0);
        strobe(16'h4E20, {6{16'h1000}});
        strobe(16'h0064, {6{16'h1000}});
        chk("blocked stays off", 32'(mem_in_use), 32'h0);
        apb(0, VAM_OFS_EVT, 32'h0);
        chk("block event", rd & 32'h408, 32'h408);
        @(posedge clk) block_in <= 0;
        apb(1, VAM_OFS_CTRL, 32'h03);
        apb(1, VAM_OFS_CURQ, 32'h01F4);
        strobe(16'h4E20, {6{16'h1000}});
        @(posedge clk) cur_mag <= {16'h0064, 16'h0064, 16'h0064};
        strobe(16'h0064, {6{16'h1000}});
        chk("low current", 32'(mem_in_use), 32'h0);
        @(posedge clk) cur_mag <= {16'h0000, 16'h0258, 16'h0000};
        strobe(16'h0064, {6{16'h1000}});
        chk("high current", 32'(mem_in_use), 32'h1);
        apb(1, VAM_OFS_CTRL, 32'h00);
        chk("disable drops", 32'(mem_in_use), 32'h0);
        strobe(16'h4E20, {6{16'h1000}});
        apb(1, VAM_OFS_CTRL, 32'h08);
        chk("nominal 60", 32'(samp_freq), 32'h1770);
        apb(1, VAM_OFS_CTRL, 32'h10);
        chk("tracked", 32'(samp_freq), 32'h1378);
        apb(1, VAM_OFS_CTRL, 32'h15);
        strobe(16'h0064, {6{16'h1000}});
        chk("current freq", 32'(samp_freq), 32'h11F8);
        chk("current freq flag", 32'(freq_from_current), 32'h1);
        apb(1, VAM_OFS_CTRL, 32'hE0);
        chk("sync valid", {31'h0, sync_ang_valid} ^ sync_ang, 32'h12341F2C);
        apb(1, VAM_OFS_CTRL, 32'h60);
        chk("sync invalid", {31'h0, sync_ang_valid} | sync_ang, 32'h0);
        conclude();
    end
endmodule // test_voltage_angle_memory
